// [osq_pkg.sv]
// constants, field layout and state types of the output sequencing and setup block
// assumes a 40 MHz core clock and a host on an I2C-compatible two-wire bus
// Operation
// [R1] output_a falls after fall-delay code steps
// [R2] output_a rises after rise-delay code steps
// [R3] output_b falls after its fall-delay steps
// [R4] output_b rises after its rise-delay steps
// [R5] startup range bit: 0.5 or 1 ms
// [R6] shutdown range bit: 0.5 or 1 ms
// [R7] output_b push-pull or open-drain, bit 6
// [R8] output_b from level, optionally trigger-gated
// [R9] output_b level bit, low or high
// [R10] output_a push-pull or open-drain, bit 2
// [R11] output_a from level, optionally trigger-gated
// [R12] output_a level bit, low or high
// [R13] shared pin: output_b or clock input
// [R14] two pull-down enables, both reset on
// [R15] thermal warning threshold 125 or 137 C
// [R16] spread spectrum enable, bit 0
// [R17] control bits 7 and 3 read zero
// [R18] delays count time base, restart on change
// [R19] software writes zero to setup bit 7
package osq_pkg;

    // register offsets
    localparam logic [7:0] OFF_A_DLY = 8'h10;
    localparam logic [7:0] OFF_B_DLY = 8'h11;
    localparam logic [7:0] OFF_CTRL  = 8'h12;
    localparam logic [7:0] OFF_SETUP = 8'h13;

    // reset values and the control read-only mask
    localparam logic [7:0] RST_DLY   = 8'h00;
    localparam logic [7:0] RST_CTRL  = 8'h44;
    localparam logic [7:0] RST_SETUP = 8'h1F;
    localparam logic [7:0] CTRL_RO_MASK = 8'h88;

    // delay register fields
    localparam int DLY_FALL_HI = 7;
    localparam int DLY_FALL_LO = 4;
    localparam int DLY_RISE_HI = 3;
    localparam int DLY_RISE_LO = 0;

    // control register fields
    localparam int CTRL_B_TYPE  = 6;
    localparam int CTRL_B_GATE  = 5;
    localparam int CTRL_B_LEVEL = 4;
    localparam int CTRL_A_TYPE  = 2;
    localparam int CTRL_A_GATE  = 1;
    localparam int CTRL_A_LEVEL = 0;

    // setup register fields
    localparam int SET_RISE_LONG  = 6;
    localparam int SET_FALL_LONG  = 5;
    localparam int SET_PIN_FUNC   = 4;
    localparam int SET_SHARED_PD  = 3;
    localparam int SET_TRIG_PD    = 2;
    localparam int SET_THERM_LVL  = 1;
    localparam int SET_SPREAD     = 0;

    // timing
    localparam int CLK_PERIOD_PS  = 25000;
    localparam int STEP_SHORT_US  = 500;
    localparam int HALF_MS_CYCLES = (STEP_SHORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // bus address, arbitrary value
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

    typedef enum logic [2:0] {
        OSQ_IDLE,
        OSQ_ADDR,
        OSQ_ADDR_ACK,
        OSQ_WRITE,
        OSQ_WRITE_ACK,
        OSQ_READ,
        OSQ_READ_ACK
    } osq_bus_state_type;

endpackage

// [osq_sync.sv]
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
module osq_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// [osq_delay_chan.sv]
// one sequenced channel: follows the trigger after a programmed delay
// assumes trig is already synchronised to core_clk
`timescale 1ns/1ps
module osq_delay_chan #(
    parameter int HALF_CYCLES = 20000
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // trigger and delay setup
    input  wire logic       trig,
    input  wire logic [3:0] rise_code,
    input  wire logic [3:0] fall_code,
    input  wire logic       rise_long,
    input  wire logic       fall_long,
    // delayed trigger
    output logic            seq
);
    localparam int PW = $clog2(HALF_CYCLES + 1);

    logic          prev_q, prev_d;
    logic          seq_q, seq_d;
    logic          pend_q, pend_d;
    logic [4:0]    tgt_q, tgt_d;
    logic [4:0]    step_q, step_d;
    logic [PW-1:0] pre_q, pre_d;
    logic          edge_now;
    logic [4:0]    tgt_now;

    assign edge_now = trig ^ prev_q;

    always_comb begin
        // long range doubles the half-millisecond step count
        if (trig) begin
            tgt_now = rise_long ? {rise_code, 1'b0} : {1'b0, rise_code}; // R2 R4 R5
        end else begin
            tgt_now = fall_long ? {fall_code, 1'b0} : {1'b0, fall_code}; // R1 R3 R6
        end
        prev_d = trig;
        seq_d  = seq_q;
        pend_d = pend_q;
        tgt_d  = tgt_q;
        step_d = step_q;
        pre_d  = pre_q;
        if (edge_now) begin
            // any change restarts the count
            pre_d  = '0; // R18
            step_d = '0;
            tgt_d  = tgt_now;
            if (tgt_now == 5'h00) begin
                seq_d  = trig;
                pend_d = 1'b0;
            end else begin
                pend_d = 1'b1;
            end
        end else if (pend_q) begin
            if (pre_q == PW'(HALF_CYCLES - 1)) begin
                pre_d  = '0;
                step_d = step_q + 5'h01; // R18
                if (step_q + 5'h01 == tgt_q) begin
                    seq_d  = trig;
                    pend_d = 1'b0;
                end
            end else begin
                pre_d = pre_q + PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev_q <= 1'b0;
            seq_q  <= 1'b0;
            pend_q <= 1'b0;
            tgt_q  <= 5'h00;
            step_q <= 5'h00;
            pre_q  <= '0;
        end else begin
            prev_q <= prev_d;
            seq_q  <= seq_d;
            pend_q <= pend_d;
            tgt_q  <= tgt_d;
            step_q <= step_d;
            pre_q  <= pre_d;
        end
    end

    assign seq = seq_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_rise_zero;
        edge_now && trig && rise_code == 4'h0 |=> seq_q;
    endproperty
    a_rise_zero: assert property (p_rise_zero) else $error("zero rise code not immediate"); // R2

    property p_fall_zero;
        edge_now && !trig && fall_code == 4'h0 |=> !seq_q;
    endproperty
    a_fall_zero: assert property (p_fall_zero) else $error("zero fall code not immediate"); // R1

    property p_hold_pending;
        pend_q && !edge_now && !(pre_q == PW'(HALF_CYCLES - 1) && step_q + 5'h01 == tgt_q)
            |=> seq_q == $past(seq_q);
    endproperty
    a_hold_pending: assert property (p_hold_pending) else $error("output moved before delay end"); // R3

    property p_restart;
        edge_now && tgt_now != 5'h00 |=> pend_q && step_q == 5'h00 && pre_q == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("delay not restarted on change"); // R18

    property p_rise_long;
        edge_now && trig && rise_long |=> tgt_q == {$past(rise_code), 1'b0};
    endproperty
    a_rise_long: assert property (p_rise_long) else $error("long rise range not doubled"); // R5

    property p_fall_short;
        edge_now && !trig && !fall_long |=> tgt_q == {1'b0, $past(fall_code)};
    endproperty
    a_fall_short: assert property (p_fall_short) else $error("short fall range wrong"); // R6

    property p_expire;
        pend_q && !edge_now && pre_q == PW'(HALF_CYCLES - 1) && step_q + 5'h01 == tgt_q
            |=> !pend_q && seq_q == $past(trig);
    endproperty
    a_expire: assert property (p_expire) else $error("delay end did not update output"); // R4

    c_long_rise: cover property (pend_q && tgt_q == 5'h1E ##1 !pend_q && seq_q);
    c_restart: cover property (pend_q && edge_now);
endmodule

// [osq_top.sv]
// output sequencing and device setup block with its two-wire register port
// assumes open-drain bus wiring and pin pads resolved outside from out/oe pairs
`timescale 1ns/1ps
module osq_top
    import osq_pkg::*;
#(
    parameter int         HALF_MS_CYC = osq_pkg::HALF_MS_CYCLES,
    parameter logic [6:0] DEV_ADDR    = osq_pkg::DEV_ADDR_DEFAULT
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // two-wire register port
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // sequence trigger pin
    input  wire logic seq_trigger_pin,
    // output_a pin
    output logic      output_a_out,
    output logic      output_a_oe,
    // shared pin as output_b
    output logic      output_b_out,
    output logic      output_b_oe,
    // setup levels to the rest of the device
    output logic      external_clock_input_sel,
    output logic      shared_pin_pulldown,
    output logic      trigger_pin_pulldown,
    output logic      thermal_warning_threshold,
    output logic      spread_spectrum_on
);
    import osq_pkg::*;

    // synchronised pins
    logic [2:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       trig_s;

    osq_sync #(
        .W (3)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in ({scl_in, sda_in, seq_trigger_pin}),
        .sync_out (pins_s)
    );

    assign scl_s  = pins_s[2];
    assign sda_s  = pins_s[1];
    assign trig_s = pins_s[0];

    // bus line history and conditions
    logic scl_p_q;
    logic sda_p_q;
    logic bus_start;
    logic bus_stop;
    logic scl_rise;
    logic scl_fall;

    assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;

    // bus engine state
    osq_bus_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic       rd_q, rd_d;
    logic       first_q, first_d;
    logic       ack_q, ack_d;
    logic       sda_oe_q, sda_oe_d;
    logic       wr_now;
    logic [7:0] rd_data;

    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        sh_d     = sh_q;
        ptr_d    = ptr_q;
        rd_d     = rd_q;
        first_d  = first_q;
        ack_d    = ack_q;
        sda_oe_d = sda_oe_q;
        wr_now   = 1'b0;
        if (bus_stop) begin
            st_d     = OSQ_IDLE;
            sda_oe_d = 1'b0;
        end else if (bus_start) begin
            st_d     = OSQ_ADDR;
            cnt_d    = 4'h0;
            sda_oe_d = 1'b0;
        end else begin
            unique case (st_q)
                OSQ_IDLE: begin
                end
                OSQ_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            sda_oe_d = 1'b1;
                            rd_d     = sh_q[0];
                            st_d     = OSQ_ADDR_ACK;
                        end else begin
                            st_d = OSQ_IDLE;
                        end
                    end
                end
                OSQ_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rd_q) begin
                            sh_d     = rd_data;
                            sda_oe_d = ~rd_data[7];
                            st_d     = OSQ_READ;
                        end else begin
                            sda_oe_d = 1'b0;
                            first_d  = 1'b1;
                            st_d     = OSQ_WRITE;
                        end
                    end
                end
                OSQ_WRITE: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        sda_oe_d = 1'b1;
                        cnt_d    = 4'h0;
                        st_d     = OSQ_WRITE_ACK;
                        // first byte sets the pointer, later bytes auto-increment
                        if (first_q) begin
                            ptr_d = sh_q;
                        end else begin
                            wr_now = 1'b1;
                            ptr_d  = ptr_q + 8'h01;
                        end
                    end
                end
                OSQ_WRITE_ACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        first_d  = 1'b0;
                        st_d     = OSQ_WRITE;
                    end
                end
                OSQ_READ: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            sda_oe_d = 1'b0;
                            ptr_d    = ptr_q + 8'h01;
                            st_d     = OSQ_READ_ACK;
                        end else begin
                            sh_d     = {sh_q[6:0], 1'b0};
                            sda_oe_d = ~sh_q[6];
                        end
                    end
                end
                OSQ_READ_ACK: begin
                    if (scl_rise) begin
                        ack_d = ~sda_s;
                    end else if (scl_fall) begin
                        if (ack_q) begin
                            sh_d     = rd_data;
                            sda_oe_d = ~rd_data[7];
                            cnt_d    = 4'h0;
                            st_d     = OSQ_READ;
                        end else begin
                            st_d = OSQ_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_p_q  <= 1'b0;
            sda_p_q  <= 1'b0;
            st_q     <= OSQ_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            ptr_q    <= 8'h00;
            rd_q     <= 1'b0;
            first_q  <= 1'b0;
            ack_q    <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            scl_p_q  <= scl_s;
            sda_p_q  <= sda_s;
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            ptr_q    <= ptr_d;
            rd_q     <= rd_d;
            first_q  <= first_d;
            ack_q    <= ack_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // register file
    logic [7:0] a_dly_q, a_dly_d;
    logic [7:0] b_dly_q, b_dly_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] setup_q, setup_d;

    always_comb begin
        a_dly_d = a_dly_q;
        b_dly_d = b_dly_q;
        ctrl_d  = ctrl_q;
        setup_d = setup_q;
        if (wr_now) begin
            unique case (ptr_q)
                OFF_A_DLY: a_dly_d = sh_q;
                OFF_B_DLY: b_dly_d = sh_q;
                OFF_CTRL:  ctrl_d  = sh_q & ~CTRL_RO_MASK; // R17
                OFF_SETUP: setup_d = sh_q; // R14 R15 R16 R19
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        unique case (ptr_q)
            OFF_A_DLY: rd_data = a_dly_q;
            OFF_B_DLY: rd_data = b_dly_q;
            OFF_CTRL:  rd_data = ctrl_q & ~CTRL_RO_MASK; // R17
            OFF_SETUP: rd_data = setup_q;
            default:   rd_data = 8'h00;
        endcase
    end

    // sequenced channels: index 0 is output_a, 1 is output_b
    logic [7:0] dly_sel [2];
    logic [1:0] seq_out;

    assign dly_sel[0] = a_dly_q;
    assign dly_sel[1] = b_dly_q;

    for (genvar g = 0; g < 2; g++) begin : g_chan
        osq_delay_chan #(
            .HALF_CYCLES (HALF_MS_CYC)
        ) u_chan (
            .core_clk  (core_clk),
            .srst      (srst),
            .trig      (trig_s),
            .rise_code (dly_sel[g][DLY_RISE_HI:DLY_RISE_LO]), // R2 R4
            .fall_code (dly_sel[g][DLY_FALL_HI:DLY_FALL_LO]), // R1 R3
            .rise_long (setup_q[SET_RISE_LONG]), // R5
            .fall_long (setup_q[SET_FALL_LONG]), // R6
            .seq       (seq_out[g])
        );
    end

    // pin drive
    logic a_val;
    logic b_val;
    logic a_out_q, a_out_d;
    logic a_oe_q, a_oe_d;
    logic b_out_q, b_out_d;
    logic b_oe_q, b_oe_d;
    logic sda_out_q;

    always_comb begin
        a_val = ctrl_q[CTRL_A_LEVEL] & (~ctrl_q[CTRL_A_GATE] | seq_out[0]); // R11 R12
        b_val = ctrl_q[CTRL_B_LEVEL] & (~ctrl_q[CTRL_B_GATE] | seq_out[1]); // R8 R9
        // open drain only pulls low
        a_out_d = ctrl_q[CTRL_A_TYPE] ? 1'b0 : a_val; // R10
        a_oe_d  = ctrl_q[CTRL_A_TYPE] ? ~a_val : 1'b1;
        if (setup_q[SET_PIN_FUNC]) begin
            b_out_d = 1'b0; // R13
            b_oe_d  = 1'b0;
        end else begin
            b_out_d = ctrl_q[CTRL_B_TYPE] ? 1'b0 : b_val; // R7
            b_oe_d  = ctrl_q[CTRL_B_TYPE] ? ~b_val : 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            a_dly_q   <= RST_DLY;
            b_dly_q   <= RST_DLY;
            ctrl_q    <= RST_CTRL;
            setup_q   <= RST_SETUP;
            a_out_q   <= 1'b0;
            a_oe_q    <= 1'b0;
            b_out_q   <= 1'b0;
            b_oe_q    <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            a_dly_q   <= a_dly_d;
            b_dly_q   <= b_dly_d;
            ctrl_q    <= ctrl_d;
            setup_q   <= setup_d;
            a_out_q   <= a_out_d;
            a_oe_q    <= a_oe_d;
            b_out_q   <= b_out_d;
            b_oe_q    <= b_oe_d;
            sda_out_q <= 1'b0;
        end
    end

    assign sda_out                   = sda_out_q;
    assign sda_oe                    = sda_oe_q;
    assign output_a_out              = a_out_q;
    assign output_a_oe               = a_oe_q;
    assign output_b_out              = b_out_q;
    assign output_b_oe               = b_oe_q;
    assign external_clock_input_sel  = setup_q[SET_PIN_FUNC]; // R13
    assign shared_pin_pulldown       = setup_q[SET_SHARED_PD]; // R14
    assign trigger_pin_pulldown      = setup_q[SET_TRIG_PD]; // R14
    assign thermal_warning_threshold = setup_q[SET_THERM_LVL]; // R15
    assign spread_spectrum_on        = setup_q[SET_SPREAD]; // R16

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_ctrl_reserved;
        wr_now && ptr_q == OFF_CTRL |=> !ctrl_q[7] && !ctrl_q[3] && ctrl_q[6] == $past(sh_q[6]);
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bits stored"); // R17

    property p_b_clock_mode;
        setup_q[SET_PIN_FUNC] |=> !output_b_oe && !output_b_out;
    endproperty
    a_b_clock_mode: assert property (p_b_clock_mode) else $error("shared pin driven in clock mode"); // R13

    property p_a_push_pull;
        !ctrl_q[CTRL_A_TYPE] && !ctrl_q[CTRL_A_GATE] |=> output_a_oe && output_a_out == $past(ctrl_q[CTRL_A_LEVEL]);
    endproperty
    a_a_push_pull: assert property (p_a_push_pull) else $error("output_a push-pull level wrong"); // R12

    property p_a_gated;
        ctrl_q[CTRL_A_GATE] && !ctrl_q[CTRL_A_TYPE] && !seq_out[0] |=> !output_a_out;
    endproperty
    a_a_gated: assert property (p_a_gated) else $error("output_a not gated by trigger"); // R11

    property p_b_open_drain;
        !setup_q[SET_PIN_FUNC] && ctrl_q[CTRL_B_TYPE] |=> !output_b_out && output_b_oe == !$past(b_val);
    endproperty
    a_b_open_drain: assert property (p_b_open_drain) else $error("output_b open-drain drive wrong"); // R7

    c_ctrl_write: cover property (wr_now && ptr_q == OFF_CTRL);
    c_read_byte: cover property (st_q == OSQ_READ_ACK && ack_q);
endmodule

// [osq_host_model.sv]
// host model on the two-wire register port, no clock stretching
// assumes the bench resolves the pulled-up data wire
`timescale 1ns/1ps
module osq_host_model (
    // clock
    input  wire logic core_clk,
    // bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_wire
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task hold;
        repeat (8) @(negedge core_clk);
    endtask
    // data changes only mid-low, sampled at end of high
    task bit_io(input logic b, output logic r);
        hold;
        sda_low = ~b;
        hold;
        scl = 1'b1;
        hold;
        r = sda_wire;
        scl = 1'b0;
    endtask
    task start;
        hold;
        sda_low = 1'b0;
        hold;
        scl = 1'b1;
        hold;
        sda_low = 1'b1;
        hold;
        scl = 1'b0;
    endtask
    task stop;
        hold;
        sda_low = 1'b1;
        hold;
        scl = 1'b1;
        hold;
        sda_low = 1'b0;
        hold;
    endtask
    task xfer(input logic [7:0] d, output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, r);
    endtask
    task write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       r0, r1, r2;
        start;
        xfer({a, 1'b0}, q, r0);
        xfer(p, q, r1);
        xfer(d, q, r2);
        stop;
        ok = ~(r0 | r1 | r2);
    endtask
    task read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       r0, r1, r2, r3;
        start;
        xfer({a, 1'b0}, q, r0);
        xfer(p, q, r1);
        start;
        xfer({a, 1'b1}, q, r2);
        xfer(8'hFF, d, r3);
        stop;
        ok = ~(r0 | r1 | r2);
    endtask
endmodule

// [output_sequencing_and_config_tb_top.sv]
// self-checking bench for osq_top through its two-wire register port
// assumes osq_host_model as host and a pulled-up data wire
`timescale 1ns/1ps
module output_sequencing_and_config_tb_top;
    import osq_pkg::*;
    localparam int H = 8;
    logic       core_clk   = 1'b0;
    logic       srst       = 1'b1;
    logic       trig       = 1'b0;
    logic       scl, sda_low, sda_oe, sda_out;
    logic       a_out, a_oe, b_out, b_oe, cks, spd, tpd, thr, ssc;
    wire        sda;
    int         n_mismatch = 0;
    int         n_compared = 0;
    int         cyc        = 0;
    int         ta, tb;
    logic [7:0] rd;
    logic       ok;
    logic [7:0] cv [4]     = '{8'h11, 8'h55, 8'h10, 8'h33};
    logic [7:0] pv [4]     = '{8'h0F, 8'h00, 8'h07, 8'h05};
    assign sda = ~(sda_low | sda_oe);
    always #12.5 core_clk = ~core_clk;
    osq_top #(.HALF_MS_CYC(H), .DEV_ADDR(DEV_ADDR_DEFAULT)) i_dut (
        .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .seq_trigger_pin(trig), .output_a_out(a_out), .output_a_oe(a_oe),
        .output_b_out(b_out), .output_b_oe(b_oe), .external_clock_input_sel(cks),
        .shared_pin_pulldown(spd), .trigger_pin_pulldown(tpd),
        .thermal_warning_threshold(thr), .spread_spectrum_on(ssc));
    osq_host_model i_host (.core_clk(core_clk), .scl(scl), .sda_low(sda_low), .sda_wire(sda));
    task test_done;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] p, input logic [7:0] d);
        i_host.write_reg(DEV_ADDR_DEFAULT, p, d, ok);
        chk({7'h0, ok}, 8'h01);
    endtask
    task rdc(input logic [7:0] p, input logic [7:0] e);
        i_host.read_reg(DEV_ADDR_DEFAULT, p, rd, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd, e);
    endtask
    // cycles from pin change to each output reaching the new level
    task seq(input logic lv, input int ea, input int eb);
        trig = lv;
        ta = -1;
        tb = -1;
        for (int i = 0; i < 120; i++) begin
            @(negedge core_clk);
            if (ta < 0 && a_out === lv) ta = i;
            if (tb < 0 && b_out === lv) tb = i;
        end
        chk({7'h0, ta >= ea && ta <= ea + 6}, 8'h01);
        chk({7'h0, tb >= eb && tb <= eb + 6}, 8'h01);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            test_done;
        end
    end
    initial begin
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk({3'h0, sda_out, a_out, a_oe, b_out, b_oe}, 8'h04);
        chk({3'h0, cks, spd, tpd, thr, ssc}, 8'h1F);
        rdc(OFF_A_DLY, 8'h00);
        rdc(OFF_B_DLY, 8'h00);
        rdc(OFF_CTRL, 8'h44);
        rdc(OFF_SETUP, 8'h1F);
        rdc(8'h20, 8'h00);
        i_host.write_reg(DEV_ADDR_DEFAULT + 7'h01, OFF_CTRL, 8'h00, ok);
        chk({7'h0, ok}, 8'h00);
        wr(OFF_CTRL, 8'hFF);
        rdc(OFF_CTRL, 8'h77);
        wr(OFF_SETUP, 8'h00);
        chk({3'h0, cks, spd, tpd, thr, ssc}, 8'h00);
        chk({4'h0, a_out, a_oe, b_out, b_oe}, 8'h05);
        for (int k = 0; k < 4; k++) begin
            wr(cv[k], 8'h00);
            wr(OFF_CTRL, cv[k]);
            chk({4'h0, a_out, a_oe, b_out, b_oe}, pv[k]);
        end
        wr(OFF_A_DLY, 8'h21);
        wr(OFF_B_DLY, 8'h03);
        seq(1'b1, H, 3 * H);
        seq(1'b0, 2 * H, 0);
        wr(OFF_SETUP, 8'h60);
        seq(1'b1, 2 * H, 6 * H);
        // fall cancelled by a rise before it expires
        trig = 1'b0;
        repeat (10) @(negedge core_clk);
        trig = 1'b1;
        ta = 0;
        repeat (100) begin
            @(negedge core_clk);
            if (a_out !== 1'b1) ta++;
        end
        chk(ta[7:0], 8'h00);
        seq(1'b0, 4 * H, 0);
        test_done;
    end
endmodule
